// ===== shared/sra_consts.svh
// constants for the serial register access port, both ends
`ifndef SRA_CONSTS_SVH
`define SRA_CONSTS_SVH

// byte and address shape
`define SRA_BYTE_W 8
`define SRA_ADDR_W 6
`define SRA_REG_CNT 64
`define SRA_LAST_BIT 3'h7
`define SRA_RW_BIT 7
`define SRA_ADDR_HI 6
`define SRA_ADDR_LO 1
`define SRA_DIR_READ 1'h1
`define SRA_DIR_WRITE 1'h0
`define SRA_PAD_BIT 1'h0
`define SRA_END_BYTE 8'h00

// timing: core clock and link rate limit
`define SRA_CORE_PERIOD_NS 40
`define SRA_MIN_BIT_NS 100
// least half period of SCK in core cycles, rounded up
`define SRA_SCK_MIN_HALF_CYC ((`SRA_MIN_BIT_NS / 2 + `SRA_CORE_PERIOD_NS - 1) / `SRA_CORE_PERIOD_NS)
// core cycles until a link input has settled through three flops
`define SRA_SYNC_LAT 4
// half period used: rate limit or synchroniser delay, the larger
`define SRA_SCK_HALF_CYC ((`SRA_SCK_MIN_HALF_CYC > `SRA_SYNC_LAT) ? `SRA_SCK_MIN_HALF_CYC : `SRA_SYNC_LAT)
`define SRA_HALF_W 3

`endif

// ===== shared/sra_pkg.sv
// types shared by both ends of the serial register access port
package sra_pkg;

   // host link sequencer states, one-hot
   typedef enum logic [3:0] {
      SRA_H_IDLE = 4'h1,
      SRA_H_LOW = 4'h2,
      SRA_H_HIGH = 4'h4,
      SRA_H_CLOSE = 4'h8
   } sra_host_state_t;

   // device state on rising SCK, cleared when select is released
   typedef struct packed {
      logic [6:0] shift;
      logic [2:0] bit_cnt;
      logic first;
      logic rd_mode;
      logic [5:0] addr;
      logic [7:0] tx;
   } sra_dev_frame_t;

   // device state on rising SCK that must outlive a frame
   typedef struct packed {
      logic wr_tgl;
      logic [5:0] wr_addr;
      logic [7:0] wr_data;
      logic rd_tgl;
      logic [5:0] rd_addr;
   } sra_dev_xfer_t;

   // device state on falling SCK
   typedef struct packed {
      logic miso;
      logic oe;
   } sra_dev_out_t;

   // device state on the core clock
   typedef struct packed {
      logic [2:0] wsync;
      logic wfilt;
      logic [2:0] rsync;
      logic rfilt;
      logic [2:0] ssync;
      logic frame;
      logic wr_valid;
      logic [5:0] wr_addr;
      logic [7:0] wr_data;
      logic rd_valid;
      logic [5:0] rd_addr;
   } sra_dev_core_t;

   // host state on the core clock
   typedef struct packed {
      sra_host_state_t state;
      logic [2:0] half;
      logic [2:0] bit_cnt;
      logic [7:0] tx;
      logic [7:0] rx;
      logic last;
      logic sck;
      logic sel_n;
      logic mosi;
      logic [2:0] msync;
      logic mfilt;
      logic ready;
      logic rsp_valid;
      logic [7:0] rsp_data;
   } sra_host_t;

endpackage

// ===== shared/sra_link_if.sv
// link wires between the host end and the device end
`timescale 1ns/100ps
interface sra_link_if;
   logic sck; // serial clock, driven by the host only
   logic slave_select_n; // frame select, active low
   logic mosi; // host to device data
   logic miso_o; // device data out
   logic miso_oe; // device drives miso while high
   logic miso; // resolved line level seen by the host

   // line idles low when nobody drives it
   assign miso = miso_oe ? miso_o : 1'b0;

   modport dev (
      input sck,
      input slave_select_n,
      input mosi,
      output miso_o,
      output miso_oe
   );

   modport host (
      output sck,
      output slave_select_n,
      output mosi,
      input miso
   );
endinterface // sra_link_if

// ===== rtl/sra_dev.sv
// device end: serial slave with its register array and core-side events
`timescale 1ns/100ps
`include "sra_consts.svh"
module sra_dev (
   sra_link_if.dev LINK,
   input wire logic CORE_CLK,
   input wire logic RST_N,
   output logic FRAME_ACTIVE,
   output logic WR_VALID,
   output logic [`SRA_ADDR_W-1:0] WR_ADDR,
   output logic [`SRA_BYTE_W-1:0] WR_DATA,
   output logic RD_VALID,
   output logic [`SRA_ADDR_W-1:0] RD_ADDR
);
   import sra_pkg::*;

   // register array reached over the link
   logic [`SRA_BYTE_W-1:0] mem [0:`SRA_REG_CNT-1];

   sra_dev_frame_t frame_ff; // rising-edge frame state
   sra_dev_frame_t nxt_frame;
   sra_dev_xfer_t xfer_ff; // crossing holders and toggles
   sra_dev_xfer_t nxt_xfer;
   sra_dev_out_t out_ff; // falling-edge output state
   sra_dev_out_t nxt_out;
   sra_dev_core_t core_ff; // core clock state
   sra_dev_core_t nxt_core;

   logic [`SRA_BYTE_W-1:0] byte_in; // byte completed on this rising edge
   logic [`SRA_ADDR_W-1:0] cmd_addr; // address field of byte_in
   logic wr_go; // data byte of a write is complete
   logic rd_go; // a read address was taken

   // address field of a command byte
   function automatic logic [`SRA_ADDR_W-1:0] addr_of(input logic [`SRA_BYTE_W-1:0] b);
      addr_of = b[`SRA_ADDR_HI:`SRA_ADDR_LO];
   endfunction

   // an event counts once the second and third flops agree on a new level
   function automatic logic settled_change(input logic [2:0] s, input logic filt);
      settled_change = (s[1] == s[2]) && (s[2] != filt);
   endfunction

   // next rising-edge state: shift in, decode command, pipeline reads
   always_comb
   begin
      nxt_frame = frame_ff;
      nxt_xfer = xfer_ff;
      wr_go = 1'b0;
      rd_go = 1'b0;
      byte_in = {frame_ff.shift, LINK.mosi};
      cmd_addr = addr_of(byte_in);
      nxt_frame.shift = byte_in[6:0];
      nxt_frame.bit_cnt = frame_ff.bit_cnt + 3'h1;
      // byte boundary reached
      if (frame_ff.bit_cnt == `SRA_LAST_BIT)
      begin
         nxt_frame.first = 1'b0;
         if (frame_ff.first)
         begin
            nxt_frame.rd_mode = (byte_in[`SRA_RW_BIT] == `SRA_DIR_READ);
            nxt_frame.addr = cmd_addr;
            // first read data goes out during byte 1
            nxt_frame.tx = (byte_in[`SRA_RW_BIT] == `SRA_DIR_READ) ? mem[cmd_addr] : `SRA_END_BYTE;
            rd_go = (byte_in[`SRA_RW_BIT] == `SRA_DIR_READ);
         end
         else if (frame_ff.rd_mode)
         begin
            // each byte names the next address
            nxt_frame.addr = cmd_addr;
            nxt_frame.tx = mem[cmd_addr];
            rd_go = 1'b1;
         end
         else
         begin
            wr_go = 1'b1;
         end
      end
      // hand write to the core side
      if (wr_go)
      begin
         nxt_xfer.wr_tgl = ~xfer_ff.wr_tgl;
         nxt_xfer.wr_addr = frame_ff.addr;
         nxt_xfer.wr_data = byte_in;
      end
      // hand read address to the core side
      if (rd_go)
      begin
         nxt_xfer.rd_tgl = ~xfer_ff.rd_tgl;
         nxt_xfer.rd_addr = cmd_addr;
      end
   end

   // rising SCK; a released select restarts the command decode
   // release clears frame
   always_ff @(posedge LINK.sck or posedge LINK.slave_select_n)
   begin
      if (LINK.slave_select_n)
      begin
         frame_ff <= '{shift: 7'h00, bit_cnt: 3'h0, first: 1'b1, rd_mode: 1'b0, addr: 6'h00, tx: 8'h00};
      end
      else
      begin
         frame_ff <= nxt_frame;
      end
   end

   // crossing holders survive frame end; cleared only by the core reset
   always_ff @(posedge LINK.sck or negedge RST_N)
   begin
      if (!RST_N)
      begin
         xfer_ff <= '{wr_tgl: 1'b0, wr_addr: 6'h00, wr_data: 8'h00, rd_tgl: 1'b0, rd_addr: 6'h00};
      end
      else
      begin
         xfer_ff <= nxt_xfer;
      end
   end

   // array write, same address for every data byte of a frame
   always_ff @(posedge LINK.sck)
   begin
      if (!LINK.slave_select_n && wr_go)
      begin
         mem[frame_ff.addr] <= byte_in;
      end
   end

   // next falling-edge state: bit of tx picked by the rising-edge count
   always_comb
   begin
      nxt_out = out_ff;
      nxt_out.miso = frame_ff.tx[`SRA_LAST_BIT - frame_ff.bit_cnt];
      nxt_out.oe = 1'b1;
   end

   always_ff @(negedge LINK.sck or posedge LINK.slave_select_n)
   begin
      if (LINK.slave_select_n)
      begin
         out_ff <= '{miso: 1'b0, oe: 1'b0};
      end
      else
      begin
         out_ff <= nxt_out;
      end
   end

   assign LINK.miso_o = out_ff.miso;
   assign LINK.miso_oe = out_ff.oe;

   // next core state: synchronise toggles and select, raise pulses
   always_comb
   begin
      nxt_core = core_ff;
      nxt_core.wsync = {core_ff.wsync[1:0], xfer_ff.wr_tgl};
      nxt_core.rsync = {core_ff.rsync[1:0], xfer_ff.rd_tgl};
      nxt_core.ssync = {core_ff.ssync[1:0], ~LINK.slave_select_n};
      nxt_core.wr_valid = 1'b0;
      nxt_core.rd_valid = 1'b0;
      // write event: holders are stable long before the next write
      if (settled_change(core_ff.wsync, core_ff.wfilt))
      begin
         nxt_core.wfilt = core_ff.wsync[2];
         nxt_core.wr_valid = 1'b1;
         nxt_core.wr_addr = xfer_ff.wr_addr;
         nxt_core.wr_data = xfer_ff.wr_data;
      end
      // read event
      if (settled_change(core_ff.rsync, core_ff.rfilt))
      begin
         nxt_core.rfilt = core_ff.rsync[2];
         nxt_core.rd_valid = 1'b1;
         nxt_core.rd_addr = xfer_ff.rd_addr;
      end
      // frame level
      if (core_ff.ssync[1] == core_ff.ssync[2])
      begin
         nxt_core.frame = core_ff.ssync[2];
      end
   end

   // core register, synchronous reset
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         core_ff <= '0;
      end
      else
      begin
         core_ff <= nxt_core;
      end
   end

   // outputs straight from core flops
   assign FRAME_ACTIVE = core_ff.frame;
   assign WR_VALID = core_ff.wr_valid;
   assign WR_ADDR = core_ff.wr_addr;
   assign WR_DATA = core_ff.wr_data;
   assign RD_VALID = core_ff.rd_valid;
   assign RD_ADDR = core_ff.rd_addr;

endmodule // sra_dev

// ===== rtl/sra_host.sv
// host end: link master that frames bytes and drives SCK
`timescale 1ns/100ps
`include "sra_consts.svh"
module sra_host (
   sra_link_if.host LINK,
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REQ_CMD,
   input wire logic REQ_READ,
   input wire logic [`SRA_ADDR_W-1:0] REQ_ADDR,
   input wire logic [`SRA_BYTE_W-1:0] REQ_DATA,
   input wire logic REQ_LAST,
   output logic RSP_VALID,
   output logic [`SRA_BYTE_W-1:0] RSP_DATA
);
   import sra_pkg::*;

   sra_host_t h_ff; // whole host state
   sra_host_t nxt_h;
   logic [`SRA_BYTE_W-1:0] out_byte; // byte to shift for a taken request
   logic half_done; // current SCK phase has run its length
   logic [`SRA_BYTE_W-1:0] rx_in; // received bits with the settled miso bit appended

   // next host state
   always_comb
   begin
      nxt_h = h_ff;
      nxt_h.rsp_valid = 1'b0;
      nxt_h.msync = {h_ff.msync[1:0], LINK.miso};
      // miso counts once second and third flops agree
      if (h_ff.msync[1] == h_ff.msync[2])
      begin
         nxt_h.mfilt = h_ff.msync[2];
      end
      // miso bit that stood at the last rising edge, seen after the synchroniser lag
      rx_in = {h_ff.rx[6:0], h_ff.mfilt};
      out_byte = REQ_CMD ? {REQ_READ, REQ_ADDR, `SRA_PAD_BIT} : REQ_DATA;
      half_done = (h_ff.half == 3'(`SRA_SCK_HALF_CYC - 1));
      nxt_h.half = half_done ? 3'h0 : h_ff.half + 3'h1;
      unique case (h_ff.state)
         SRA_H_IDLE:
         begin
            // sck idles low; select stays low between bytes of a frame
            nxt_h.half = 3'h0;
            if (REQ_VALID && h_ff.ready)
            begin
               nxt_h.sel_n = 1'b0;
               nxt_h.tx = out_byte;
               nxt_h.mosi = out_byte[7];
               nxt_h.last = REQ_LAST;
               nxt_h.bit_cnt = 3'h0;
               nxt_h.ready = 1'b0;
               nxt_h.state = SRA_H_LOW;
            end
         end
         SRA_H_LOW:
         begin
            if (half_done)
            begin
               // rising edge; miso is taken at the end of the high half
               // host makes the clock
               nxt_h.sck = 1'b1;
               nxt_h.state = SRA_H_HIGH;
            end
         end
         SRA_H_HIGH:
         begin
            if (half_done)
            begin
               nxt_h.sck = 1'b0;
               // capture late: the synchroniser needs four edges after a miso change
               nxt_h.rx = rx_in;
               nxt_h.bit_cnt = h_ff.bit_cnt + 3'h1;
               if (h_ff.bit_cnt == `SRA_LAST_BIT)
               begin
                  nxt_h.rsp_valid = 1'b1;
                  nxt_h.rsp_data = rx_in;
                  nxt_h.state = h_ff.last ? SRA_H_CLOSE : SRA_H_IDLE;
                  nxt_h.ready = !h_ff.last;
               end
               else
               begin
                  nxt_h.tx = {h_ff.tx[6:0], 1'b0};
                  nxt_h.mosi = h_ff.tx[6];
                  nxt_h.state = SRA_H_LOW;
               end
            end
         end
         SRA_H_CLOSE:
         begin
            // hold select one half period after the last edge
            if (half_done)
            begin
               nxt_h.sel_n = 1'b1;
               nxt_h.ready = 1'b1;
               nxt_h.state = SRA_H_IDLE;
            end
         end
      endcase
   end

   // host register, synchronous reset
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         h_ff <= '{state: SRA_H_IDLE, half: 3'h0, bit_cnt: 3'h0, tx: 8'h00, rx: 8'h00, last: 1'b0,
                   sck: 1'b0, sel_n: 1'b1, mosi: 1'b0, msync: 3'h0, mfilt: 1'b0, ready: 1'b1,
                   rsp_valid: 1'b0, rsp_data: 8'h00};
      end
      else
      begin
         h_ff <= nxt_h;
      end
   end

   // link and user outputs straight from flops
   assign LINK.sck = h_ff.sck;
   assign LINK.slave_select_n = h_ff.sel_n;
   assign LINK.mosi = h_ff.mosi;
   assign REQ_READY = h_ff.ready;
   assign RSP_VALID = h_ff.rsp_valid;
   assign RSP_DATA = h_ff.rsp_data;

endmodule // sra_host

// ===== testbench/sra_link_chk.sv
// checker for framing and timing on the link wires
`timescale 1ns/100ps
module sra_link_chk (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic sck,
   input wire logic slave_select_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso
);
   import sra_pkg::*;
   logic sck_d_ff; // sck one core cycle ago
   logic [2:0] bit_ff; // rising sck edges in this frame, modulo one byte
   // count bit clocks inside a frame, cleared while select is high
   always_ff @(posedge CORE_CLK)
   begin
      sck_d_ff <= sck;
      if (!RST_N || slave_select_n)
         bit_ff <= 3'h0;
      else if (sck && !sck_d_ff)
         bit_ff <= bit_ff + 3'h1;
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // sck held at one level for a half period
   sequence s_lo4; !sck [*4]; endsequence
   sequence s_hi4; sck [*4]; endsequence
   property p_sck_idle; slave_select_n |-> !sck; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck moves outside a frame");
   property p_sel_start; $fell(slave_select_n) |-> s_lo4 ##1 sck; endproperty
   a_sel_start: assert property (p_sel_start) else $error("first bit clock misplaced");
   property p_sck_hi; $rose(sck) |-> s_hi4 ##1 !sck; endproperty
   a_sck_hi: assert property (p_sck_hi) else $error("sck high half wrong length");
   property p_sck_lo; $fell(sck) && !slave_select_n |-> s_lo4; endproperty
   a_sck_lo: assert property (p_sck_lo) else $error("sck low half too short");
   property p_mosi_hold; sck |-> $stable(mosi); endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sck high");
   property p_miso_hold; sck |-> $stable(miso_o); endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sck high");
   property p_oe_on; !slave_select_n && $fell(sck) |-> miso_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
   property p_oe_off; slave_select_n |-> !miso_oe && !miso; endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven without select");
   property p_whole; $rose(slave_select_n) |-> bit_ff == 3'h0; endproperty
   a_whole: assert property (p_whole) else $error("frame ended mid byte");
   property p_sel_end; $rose(slave_select_n) |-> !sck && !$past(sck); endproperty
   a_sel_end: assert property (p_sel_end) else $error("select released with sck high");
endmodule // sra_link_chk

// ===== testbench/testbench.sv
// bench: host end and device end joined, writes and pipelined reads
`timescale 1ns/100ps
module testbench;
   import sra_pkg::*;
   logic core_clk, rst_n, req_valid, req_ready, req_cmd, req_read, req_last, rsp_valid;
   logic [5:0] req_addr, wr_addr, rd_addr, a1, a2;
   logic [7:0] req_data, rsp_data, wr_data, d0, d1, d2;
   logic frame_active, wr_valid, rd_valid;
   logic [7:0] mem [64]; // mirror of what was written
   logic [8:0] rsp_q [$]; // care flag and expected response
   logic [13:0] wr_q [$]; // expected write address and data
   logic [5:0] rd_q [$]; // expected read addresses
   int error_cnt = 0;
   int n_compared = 0;
   int seed;
   sra_link_if link ();
   sra_host i_sra_host (.LINK(link), .CORE_CLK(core_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_READ(req_read), .REQ_ADDR(req_addr),
      .REQ_DATA(req_data), .REQ_LAST(req_last), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
   sra_dev i_sra_dev (.LINK(link), .CORE_CLK(core_clk), .RST_N(rst_n), .FRAME_ACTIVE(frame_active),
      .WR_VALID(wr_valid), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_ADDR(rd_addr));
   sra_link_chk i_sra_link_chk (.CORE_CLK(core_clk), .RST_N(rst_n), .sck(link.sck),
      .slave_select_n(link.slave_select_n), .mosi(link.mosi), .miso_o(link.miso_o),
      .miso_oe(link.miso_oe), .miso(link.miso));
   // core clock, 40 ns period
   always #20 core_clk = ~core_clk;
   // one comparison, reported on mismatch
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // print counts and verdict, then stop
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hand one byte to the host; valid stays up for back to back bytes
   task automatic xfer(input logic cmd, input logic [7:0] d, input logic last, input logic care,
      input logic [7:0] e);
      rsp_q.push_back({care, e});
      @(negedge core_clk);
      req_valid = 1'b1;
      req_cmd = cmd;
      req_read = d[7];
      req_addr = d[6:1];
      req_data = d;
      req_last = last;
      while (req_ready !== 1'b1)
         @(negedge core_clk);
      @(posedge core_clk);
   endtask
   // result watcher: each pulse takes the oldest note
   always @(negedge core_clk)
   begin
      if (rsp_valid === 1'b1)
      begin
         if (rsp_q.size() == 0)
            check("rsp_extra", 16'h0000, 16'h0001);
         else if (rsp_q[0][8])
            check("rsp_data", {8'h00, rsp_q[0][7:0]}, {8'h00, rsp_data});
         if (rsp_q.size() != 0)
            void'(rsp_q.pop_front());
      end
      if (wr_valid === 1'b1)
      begin
         if (wr_q.size() == 0)
            check("wr_extra", 16'h0000, 16'h0001);
         else
            check("wr_pair", {2'h0, wr_q.pop_front()}, {2'h0, wr_addr, wr_data});
         check("frame_busy", 16'h0001, {15'h0000, frame_active});
      end
      if (rd_valid === 1'b1)
      begin
         if (rd_q.size() == 0)
            check("rd_extra", 16'h0000, 16'h0001);
         else
            check("rd_addr", {10'h000, rd_q.pop_front()}, {10'h000, rd_addr});
      end
   end
   // watchdog well beyond the expected run
   initial
   begin
      repeat (30000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
   // main sequence: five rounds of two write frames, then a pipelined read frame
   initial
   begin
      core_clk = 1'b0;
      // start high, then fall: the link-side holders need a real falling reset edge
      rst_n = 1'b1;
      req_valid = 1'b0;
      req_cmd = 1'b0;
      req_read = 1'b0;
      req_addr = 6'h00;
      req_data = 8'h00;
      req_last = 1'b0;
      seed = $urandom(32'hD1F0);
      #1 rst_n = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      check("frame_idle", 16'h0000, {15'h0000, frame_active});
      for (int it = 0; it < 5; it++)
      begin
         a1 = 6'($urandom);
         a2 = (it == 4) ? 6'h00 : 6'($urandom);
         a1 = (it == 3) ? 6'h3F : a1;
         d0 = 8'($urandom);
         d1 = 8'($urandom);
         d2 = 8'($urandom);
         wr_q.push_back({a1, d0});
         wr_q.push_back({a1, d1});
         xfer(1'b1, {1'b0, a1, 1'b0}, 1'b0, 1'b0, 8'h00);
         xfer(1'b0, d0, 1'b0, 1'b0, 8'h00);
         xfer(1'b0, d1, 1'b1, 1'b0, 8'h00);
         mem[a1] = d1;
         wr_q.push_back({a2, d2});
         xfer(1'b1, {1'b0, a2, 1'b0}, 1'b0, 1'b0, 8'h00);
         xfer(1'b0, d2, 1'b1, 1'b0, 8'h00);
         mem[a2] = d2;
         rd_q.push_back(a1);
         rd_q.push_back(a2);
         rd_q.push_back(6'h00);
         xfer(1'b1, {1'b1, a1, 1'b0}, 1'b0, 1'b0, 8'h00);
         xfer(1'b0, {1'b1, a2, 1'b0}, 1'b0, 1'b1, mem[a1]);
         xfer(1'b0, 8'h00, 1'b1, 1'b1, mem[a2]);
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      // let the last byte finish and the select release settle
      while (req_ready !== 1'b1)
         @(negedge core_clk);
      repeat (20) @(negedge core_clk);
      check("frame_end", 16'h0000, {15'h0000, frame_active});
      check("notes_left", 16'h0000, 16'(rsp_q.size() + wr_q.size() + rd_q.size()));
      report_and_stop();
   end
endmodule // testbench
